// *** siv_cfg.svh ***
// Purpose: offsets, field positions, reset values and codes of the line-1 vector block
// Assumes: byte offsets on an 8-bit register port with 32-bit data
// Notes: definitions only
`ifndef SIV_CFG_SVH
`define SIV_CFG_SVH

// register byte offsets
`define SIV_OFS_ENABLE 8'h00
`define SIV_OFS_LEVEL 8'h04
`define SIV_OFS_FLAG 8'h08
`define SIV_OFS_VECTOR 8'h0c
`define SIV_OFS_IRQ_STAT 8'h10
`define SIV_OFS_IRQ_MASK 8'h14

// source bit positions in enable, level and flag registers
`define SIV_ERR_LSB 0
`define SIV_ERR_W 4
`define SIV_BIT_OVR 6
`define SIV_BIT_RX 8
`define SIV_BIT_ERR_LVL 0
`define SIV_BUF_LSB 12
`define SIV_BUF_W 4

// vector field position and codes
`define SIV_VEC_LSB 1
`define SIV_VEC_W 5
`define SIV_VEC_NONE 5'h00
`define SIV_VEC_ERR 5'h11
`define SIV_VEC_RX 5'h12
`define SIV_VEC_OVR 5'h13

// irq status and mask bit positions
`define SIV_IRQ_W 3
`define SIV_IRQ_OVR 0
`define SIV_IRQ_RX 1
`define SIV_IRQ_ERR 2

// reset values
`define SIV_RST_WORD 32'h0000_0000
`define SIV_RST_FLAGS 9'h000

`endif

// *** siv_pkg.sv ***
// Purpose: types shared by the line-1 vector block
// Assumes: siv_cfg.svh holds the numbers
// Notes: vector codes as an enum
`include "siv_cfg.svh"

package siv_pkg;
  typedef enum logic [4:0] {
    SIV_NONE = `SIV_VEC_NONE,
    SIV_ERR = `SIV_VEC_ERR,
    SIV_RX = `SIV_VEC_RX,
    SIV_OVR = `SIV_VEC_OVR
  } siv_vec_t;

  typedef logic [7:0] siv_addr_t;
  typedef logic [31:0] siv_word_t;
endpackage : siv_pkg

// *** siv_flags.sv ***
// Purpose: bank of sticky flags with per-bit set and clear
// Assumes: synchronous active-low reset
// Notes: set wins over clear in the same cycle
`include "siv_cfg.svh"

module siv_flags #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // set and clear requests
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // flag state
  output logic [W-1:0] q
);

  // an event landing on the clearing cycle must survive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule : siv_flags

// *** siv_prio.sv ***
// Purpose: picks the vector of the highest-ranked pending source
// Assumes: pending inputs already gated by enable and line routing
// Notes: purely combinational
`include "siv_cfg.svh"

module siv_prio (
  // pending sources
  input wire logic ovr_pend,
  input wire logic rx_pend,
  input wire logic err_pend,
  // chosen code
  output siv_pkg::siv_vec_t vec
);

  always_comb begin
    if (ovr_pend) begin
      vec = siv_pkg::SIV_OVR;
    end else if (rx_pend) begin
      vec = siv_pkg::SIV_RX;
    end else if (err_pend) begin
      vec = siv_pkg::SIV_ERR;
    end else begin
      vec = siv_pkg::SIV_NONE;
    end
  end

endmodule : siv_prio

// *** siv_top.sv ***
// Purpose: line-1 interrupt vector register with its flag, enable and routing state
// Assumes: register port strobes one cycle, never both at once
// Notes: read data stand one cycle after the read strobe
`include "siv_cfg.svh"

module siv_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // events from the serial core
  input wire logic rx_evt,
  input wire logic ovr_evt,
  input wire logic [3:0] err_evt,
  input wire logic [3:0] err_buffer,
  // interrupt outputs
  output logic second_interrupt_output,
  output logic irq
);

  // register state
  logic [31:0] enable_reg;
  logic [31:0] level_reg;
  logic [`SIV_IRQ_W-1:0] irq_mask_reg;
  logic [`SIV_BUF_W-1:0] err_buf_reg;
  logic [31:0] rdata_reg;
  logic line1_reg;
  logic irq_reg;

  // flag bank: bits 3..0 error types, 4 overrun, 5 receive
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [5:0] flag_q;
  logic [`SIV_IRQ_W-1:0] stat_set;
  logic [`SIV_IRQ_W-1:0] stat_clr;
  logic [`SIV_IRQ_W-1:0] stat_q;

  // decode
  logic wr_enable;
  logic wr_level;
  logic wr_flag;
  logic wr_mask;
  logic rd_vector;
  logic rd_stat;

  // flag bank fields and line-1 routing
  logic [3:0] flag_err;
  logic flag_ovr;
  logic flag_rx;
  logic [3:0] err_hit;
  logic ovr_route;
  logic rx_route;
  logic err_route;

  // gated pending terms
  logic ovr_pend;
  logic rx_pend;
  logic err_pend;
  siv_pkg::siv_vec_t vec_now;

  // clear sources and next values
  logic [5:0] wr_clr;
  logic [5:0] rd_clr;
  logic [`SIV_IRQ_W-1:0] stat_next;
  logic [31:0] rdata_next;
  logic line1_next;
  logic irq_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // packs per-source fields into the shared enable, level and flag layout
  function automatic logic [31:0] src_word(input logic [3:0] e, input logic o, input logic r);
    src_word = 32'h0000_0000;
    src_word[`SIV_ERR_LSB +: `SIV_ERR_W] = e;
    src_word[`SIV_BIT_OVR] = o;
    src_word[`SIV_BIT_RX] = r;
  endfunction : src_word

  // code in bits 5..1, every other bit reads zero
  function automatic logic [31:0] vec_word(input siv_pkg::siv_vec_t v);
    vec_word = 32'h0000_0000;
    vec_word[`SIV_VEC_LSB +: `SIV_VEC_W] = v;
  endfunction : vec_word

  assign wr_enable = wr_en && hit(addr, `SIV_OFS_ENABLE);
  assign wr_level = wr_en && hit(addr, `SIV_OFS_LEVEL);
  assign wr_flag = wr_en && hit(addr, `SIV_OFS_FLAG);
  assign wr_mask = wr_en && hit(addr, `SIV_OFS_IRQ_MASK);
  assign rd_vector = rd_en && hit(addr, `SIV_OFS_VECTOR);
  assign rd_stat = rd_en && hit(addr, `SIV_OFS_IRQ_STAT);

  // enable register: error enables, overrun and receive enables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable_reg <= `SIV_RST_WORD;
    end else if (wr_enable) begin
      enable_reg <= 32'h0000_0000;
      enable_reg[`SIV_ERR_LSB +: `SIV_ERR_W] <= wdata[`SIV_ERR_LSB +: `SIV_ERR_W];
      enable_reg[`SIV_BIT_OVR] <= wdata[`SIV_BIT_OVR];
      enable_reg[`SIV_BIT_RX] <= wdata[`SIV_BIT_RX];
    end
  end

  // level register: a one routes the source to line 1
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level_reg <= `SIV_RST_WORD;
    end else if (wr_level) begin
      level_reg <= 32'h0000_0000;
      level_reg[`SIV_BIT_ERR_LVL] <= wdata[`SIV_BIT_ERR_LVL];
      level_reg[`SIV_BIT_OVR] <= wdata[`SIV_BIT_OVR];
      level_reg[`SIV_BIT_RX] <= wdata[`SIV_BIT_RX];
    end
  end

  // interrupt mask
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= wdata[`SIV_IRQ_W-1:0];
    end
  end

  // buffer of the last error, kept for software to examine
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      err_buf_reg <= '0;
    end else if (|err_evt) begin
      err_buf_reg <= err_buffer;
    end
  end

  // named views of the flag bank
  assign flag_err = flag_q[3:0];
  assign flag_ovr = flag_q[4];
  assign flag_rx = flag_q[5];

  // a source counts for line 1 only when enabled and routed here
  assign ovr_route = enable_reg[`SIV_BIT_OVR] && level_reg[`SIV_BIT_OVR];
  assign rx_route = enable_reg[`SIV_BIT_RX] && level_reg[`SIV_BIT_RX];
  assign err_route = level_reg[`SIV_BIT_ERR_LVL];
  // error types share one routing bit, each type has its own enable
  assign err_hit = flag_err & enable_reg[`SIV_ERR_LSB +: `SIV_ERR_W];

  // gate by enable and line routing
  assign ovr_pend = flag_ovr && ovr_route;
  assign rx_pend = flag_rx && rx_route;
  assign err_pend = (|err_hit) && err_route;

  siv_prio u_prio (
    .ovr_pend(ovr_pend),
    .rx_pend(rx_pend),
    .err_pend(err_pend),
    .vec(vec_now)
  );

  // write-one clears from software
  always_comb begin
    wr_clr = 6'h00;
    if (wr_flag) begin
      wr_clr[3:0] = wdata[`SIV_ERR_LSB +: `SIV_ERR_W];
      wr_clr[4] = wdata[`SIV_BIT_OVR];
      wr_clr[5] = wdata[`SIV_BIT_RX];
    end
  end

  // decided on the live code so back-to-back reads never clear twice
  always_comb begin
    rd_clr = 6'h00;
    if (rd_vector && vec_now == siv_pkg::SIV_OVR) begin
      rd_clr[4] = 1'b1;
    end
    if (rd_vector && vec_now == siv_pkg::SIV_RX) begin
      rd_clr[5] = 1'b1;
    end
    // error flags stay until software clears them
    if (rd_vector && vec_now == siv_pkg::SIV_ERR) begin
      rd_clr[3:0] = 4'h0;
    end
  end

  // events set; a set wins over a clear in the same cycle
  always_comb begin
    flag_set = {rx_evt, ovr_evt, err_evt};
    flag_clr = wr_clr | rd_clr;
  end

  siv_flags #(.W(6)) u_flags (
    .clock(clock),
    .rst_n(rst_n),
    .set(flag_set),
    .clr(flag_clr),
    .q(flag_q)
  );

  // sticky event status, cleared by reading it
  always_comb begin
    stat_set = '0;
    stat_set[`SIV_IRQ_OVR] = ovr_evt;
    stat_set[`SIV_IRQ_RX] = rx_evt;
    stat_set[`SIV_IRQ_ERR] = |err_evt;
    stat_clr = rd_stat ? {`SIV_IRQ_W{1'b1}} : '0;
  end

  // same value the status bank takes at this edge
  assign stat_next = (stat_q & ~stat_clr) | stat_set;

  siv_flags #(.W(`SIV_IRQ_W)) u_stat (
    .clock(clock),
    .rst_n(rst_n),
    .set(stat_set),
    .clr(stat_clr),
    .q(stat_q)
  );

  // read mux; unmapped offsets and unwritable bits give zero, except the error buffer in enable bits 15..12
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        `SIV_OFS_ENABLE: begin
          rdata_next = enable_reg;
          rdata_next[`SIV_BUF_LSB +: `SIV_BUF_W] = err_buf_reg;
        end
        `SIV_OFS_LEVEL: begin
          rdata_next = level_reg;
        end
        `SIV_OFS_FLAG: begin
          rdata_next = src_word(flag_err, flag_ovr, flag_rx);
        end
        `SIV_OFS_VECTOR: begin
          rdata_next = vec_word(vec_now);
        end
        `SIV_OFS_IRQ_STAT: begin
          rdata_next[`SIV_IRQ_W-1:0] = stat_q;
        end
        `SIV_OFS_IRQ_MASK: begin
          rdata_next[`SIV_IRQ_W-1:0] = irq_mask_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data stand one cycle after the strobe, zero elsewhere
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_reg <= `SIV_RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // line 1 output follows the live vector one cycle late
  assign line1_next = (vec_now != siv_pkg::SIV_NONE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      line1_reg <= 1'b0;
    end else begin
      line1_reg <= line1_next;
    end
  end

  // irq rises with the status bit; a mask write takes hold one edge later
  assign irq_next = |(stat_next & irq_mask_reg);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign second_interrupt_output = line1_reg;
  assign irq = irq_reg;

endmodule : siv_top

// *** siv_top_properties.sv ***
// Purpose: port-level checks of the line-1 vector block
// Assumes: reads on the register port answer one cycle later
// Notes: bound to siv_top below
module siv_top_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // events and outputs
  input wire logic rx_evt,
  input wire logic ovr_evt,
  input wire logic [3:0] err_evt,
  input wire logic second_interrupt_output,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic vec_rd;
  assign vec_rd = rd_en && addr == 8'h0c;
  property p_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  property p_rsvd; $past(rd_en) && $past(addr) == 8'h0c |-> rdata[31:6] == 26'h0 && !rdata[0];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_code; vec_rd |=> rdata[5:1] inside {5'h00, 5'h11, 5'h12, 5'h13}; endproperty
  a_code: assert property (p_code) else $error("illegal code");
  property p_line; vec_rd |=> second_interrupt_output == (rdata[5:1] != 5'h00); endproperty
  a_line: assert property (p_line) else $error("line1 output disagrees");
  property p_ovr; vec_rd && !ovr_evt ##1 vec_rd && rdata[5:1] == 5'h13 |=> rdata[5:1] != 5'h13;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not cleared");
  property p_rx; vec_rd && !rx_evt ##1 vec_rd && rdata[5:1] == 5'h12 |=> rdata[5:1] != 5'h12;
  endproperty
  a_rx: assert property (p_rx) else $error("receive not cleared");
  property p_err;
    vec_rd && !rx_evt && !ovr_evt ##1 vec_rd && rdata[5:1] == 5'h11 |=> rdata[5:1] == 5'h11;
  endproperty
  a_err: assert property (p_err) else $error("error vector lost");
  property p_irq;
    rd_en && addr == 8'h10 && !rx_evt && !ovr_evt && err_evt == 4'h0
      ##1 !rx_evt && !ovr_evt && err_evt == 4'h0 |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq after status read");
  c_ovr: cover property (vec_rd ##1 rdata[5:1] == 5'h13);
  c_err: cover property (vec_rd ##1 rdata[5:1] == 5'h11);
  c_irq: cover property (irq);
endmodule : siv_top_props

bind siv_top siv_top_props i_siv_top_props (.clock(clock), .rst_n(rst_n), .addr(addr),
  .rd_en(rd_en), .rdata(rdata), .rx_evt(rx_evt), .ovr_evt(ovr_evt), .err_evt(err_evt),
  .second_interrupt_output(second_interrupt_output), .irq(irq));

// *** siv_evt_src.sv ***
// Purpose: serial core stand-in raising events
// Assumes: pattern word changes each cycle
// Notes: sparse registered pulses
module siv_evt_src (
  // clock
  input wire logic clock,
  // pattern
  input wire logic [31:0] er,
  // events
  output logic rx_evt,
  output logic ovr_evt,
  output logic [3:0] err_evt,
  output logic [3:0] err_buffer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {rx_evt, ovr_evt, err_evt, err_buffer} = 10'h000;
  end
  always @(posedge clock) begin
    rx_evt <= &er[31:30];
    ovr_evt <= &er[29:27];
    err_evt <= er[3:0] & {4{&er[26:25]}};
    err_buffer <= er[7:4];
  end
endmodule : siv_evt_src

// *** siv_top_tb.sv ***
// Purpose: self-checking bench for siv_top
// Assumes: error pending needs flag and its type enable
// Notes: model compared every cycle
module siv_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_n = 0, wr_en = 0, rd_en = 0, go = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, er = 32'h0, seed = 32'h5d99, rdata;
  logic rx_evt, ovr_evt, second_interrupt_output, irq;
  logic [3:0] err_evt, err_buffer;
  logic [31:0] en, lvl, flg, st, msk, eb, vec, x_rd, x_soi, x_irq;
  int n_errors = 0, checks = 0;
  siv_top i_siv_top (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_evt(rx_evt), .ovr_evt(ovr_evt),
    .err_evt(err_evt), .err_buffer(err_buffer),
    .second_interrupt_output(second_interrupt_output), .irq(irq));
  siv_evt_src i_siv_evt_src (.clock(clock), .er(er), .rx_evt(rx_evt), .ovr_evt(ovr_evt),
    .err_evt(err_evt), .err_buffer(err_buffer));
  initial begin
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // reference model: state before the edge decides the answer
  always @(posedge clock) begin
    go <= 1'b1;
    vec = flg[6] & en[6] & lvl[6] ? 32'h13 : flg[8] & en[8] & lvl[8] ? 32'h12 :
      (|(flg[3:0] & en[3:0])) & lvl[0] ? 32'h11 : 32'h0;
    x_soi = {31'h0, vec != 32'h0};
    x_rd = 32'h0;
    if (rd_en) begin
      case (addr)
        8'h00: x_rd = en | (eb << 12);
        8'h04: x_rd = lvl;
        8'h08: x_rd = flg;
        8'h0c: x_rd = vec << 1;
        8'h10: x_rd = st;
        8'h14: x_rd = msk;
        default: x_rd = 32'h0;
      endcase
    end
    if (rd_en && addr == 8'h0c && vec == 32'h13) flg[6] = 1'b0;
    if (rd_en && addr == 8'h0c && vec == 32'h12) flg[8] = 1'b0;
    if (rd_en && addr == 8'h10) st = 32'h0;
    if (wr_en && addr == 8'h00) en = wdata & 32'h14f;
    if (wr_en && addr == 8'h04) lvl = wdata & 32'h141;
    if (wr_en && addr == 8'h08) flg = flg & ~wdata;
    flg = flg | {23'h0, rx_evt, 1'b0, ovr_evt, 2'b0, err_evt};
    st = st | {29'h0, |err_evt, rx_evt, ovr_evt};
    x_irq = {31'h0, |(st[2:0] & msk[2:0])};
    if (wr_en && addr == 8'h14) msk = wdata & 32'h7;
    if (|err_evt) eb = {28'h0, err_buffer};
    if (!rst_n) begin
      {en, lvl, flg, st, msk, eb, x_rd, x_soi, x_irq} = '0;
    end
  end
  always @(negedge clock) begin
    if (go) begin
      check("rdata", rdata, x_rd);
      check("line1", {31'h0, second_interrupt_output}, x_soi);
      check("irq", {31'h0, irq}, x_irq);
    end
  end
  task automatic op(input logic w, r, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge clock);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    er <= e;
  endtask : op
  task automatic cyc(input int n);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      op(seed[1:0] == 2'd1, seed[1:0] == 2'd0, seed[5] ? 8'h0c : {3'h0, seed[4:2], 2'b00},
        xs(seed ^ 32'h9e37), xs(seed + 32'h1));
    end
  endtask : cyc
  task automatic setup;
    op(1, 0, 8'h00, 32'h14f, 0);
    op(1, 0, 8'h04, 32'h141, 0);
    op(1, 0, 8'h14, 32'h7, 32'hffff_ffff);
    op(0, 0, 8'h00, 0, 0);
    repeat (4) op(0, 1, 8'h0c, 0, 0);
    op(0, 1, 8'h10, 0, 0);
    op(0, 1, 8'h00, 0, 0);
    op(1, 0, 8'h0c, 32'hffff_ffff, 0);
    op(1, 0, 8'h08, 32'hf, 0);
    op(0, 1, 8'h0c, 0, 0);
  endtask : setup
  initial begin
    #5000000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    setup();
    cyc(3000);
    op(0, 0, 8'h00, 0, 0);
    rst_n <= 1'b0;
    op(0, 0, 8'h00, 0, 0);
    rst_n <= 1'b1;
    setup();
    cyc(1000);
    op(0, 0, 8'h00, 0, 0);
    repeat (2) @(posedge clock);
    test_done();
  end
endmodule : siv_top_tb
